// *** core/eif_map.svh ***
// Purpose: register indices, field positions, reset values and timing counts
//          for the two-channel external request edge and noise filter block
// Assumes: included by its bare name from the design files
// Notes:   indices are word indices; the byte address is four times the index
//
// Summary of operation
// - edge code 00 requests on filtered rise
// - edge code 01 requests on filtered fall
// - code 10 both edges; 11 reserved, silent
// - read-only level flag, zero after reset
// - fast modes sample at gear/1,4,8,16
// - slow modes sample at low clock/4
// - control bits 7 to 5 read zero
// - control writes may glitch; mask first
// - level flag refreshed at every request
// - power enable low freezes channel, ignores writes
`ifndef EIF_MAP_SVH
`define EIF_MAP_SVH

// word indices of the registers
`define EIF_CH2_CTRL_IDX 14'h0FD9
`define EIF_CH3_CTRL_IDX 14'h0FDA
`define EIF_POWER_IDX 14'h0F77

// control register fields
`define EIF_NC_LSB 0
`define EIF_ES_LSB 2
`define EIF_LVL_BIT 4
`define EIF_CTRL_RST 8'h00

// power and mode register fields
`define EIF_PWR_CH2_BIT 2
`define EIF_PWR_CH3_BIT 3
`define EIF_PWR_SLOW_BIT 7
`define EIF_PWR_RST 8'h00

// low clock edges per slow-mode sample
`define EIF_SLOW_DIV 4
// agreeing samples the canceller needs before it moves
`define EIF_FILT_SAMPLES 3

`endif

// *** core/eif_pkg.sv ***
// Purpose: types shared by the filter block
// Assumes: nothing beyond the map header
// Notes:   no constants of number here but the gear divider end counts; the rest live in the map header
package eif_pkg;

  // edge select codes
  typedef enum logic [1:0] {
    EIF_ES_RISE = 2'b00,
    EIF_ES_FALL = 2'b01,
    EIF_ES_BOTH = 2'b10,
    EIF_ES_RSVD = 2'b11
  } eif_edge_type;

  // filter interval codes for the fast modes
  typedef enum logic [1:0] {
    EIF_NC_DIV1 = 2'b00,
    EIF_NC_DIV4 = 2'b01,
    EIF_NC_DIV8 = 2'b10,
    EIF_NC_DIV16 = 2'b11
  } eif_interval_type;

  // bus slave states
  typedef enum logic {
    EIF_BUS_IDLE = 1'b0,
    EIF_BUS_ACK = 1'b1
  } eif_bus_type;

  // last count of the gear divider for a given interval code
  function automatic logic [3:0] eif_terminal(input eif_interval_type code);
    case (code)
      EIF_NC_DIV1: eif_terminal = 4'h0;
      EIF_NC_DIV4: eif_terminal = 4'h3;
      EIF_NC_DIV8: eif_terminal = 4'h7;
      default: eif_terminal = 4'hF;
    endcase
  endfunction

endpackage

// *** core/eif_sync.sv ***
// Purpose: two flip-flop synchroniser for levels from outside the clock
// Assumes: each bit is an independent slow level
// Notes:   the first stage is read by the second stage only
`timescale 1ns/100ps
module eif_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff; // first stage, may go metastable
  logic [WIDTH-1:0] sync_ff; // second stage, safe to use

  initial begin
    if (WIDTH < 1) begin
      $error("eif_sync needs a width of at least one");
    end
  end

  // two stages, reset to zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

// *** core/eif_chan.sv ***
// Purpose: one channel: noise canceller, edge detector and request pulse
// Assumes: pin already synchronised; smpl_i is a one-cycle sample enable
// Notes:   with run_i low the filter and history flops hold and req_o is held low; a held half-filled window can give one stray request on waking
`timescale 1ns/100ps
`include "eif_map.svh"
module eif_chan #(
  parameter int FILT_SAMPLES = `EIF_FILT_SAMPLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic smpl_i,
  input wire logic pin_i,
  input wire eif_pkg::eif_edge_type edge_sel_i,
  output logic req_o,
  output logic filt_o
);

  logic [FILT_SAMPLES-1:0] win_ff; // recent samples
  logic [FILT_SAMPLES-1:0] nxt_win; // window after this sample
  logic filt_ff; // canceller output level
  logic prev_ff; // canceller output one cycle ago
  logic req_ff; // request pulse
  logic hit; // selected edge seen now

  initial begin
    if (FILT_SAMPLES < 2 || FILT_SAMPLES > 8) begin
      $error("eif_chan supports two to eight filter samples");
    end
  end

  assign nxt_win = {win_ff[FILT_SAMPLES-2:0], pin_i};

  // canceller moves only when the whole window agrees
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_ff <= '0;
      filt_ff <= 1'b0;
    end else if (run_i && smpl_i) begin
      win_ff <= nxt_win;
      if (&nxt_win) begin
        filt_ff <= 1'b1;
      end else if (~|nxt_win) begin
        filt_ff <= 1'b0;
      end
    end
  end

  // edge selection on the filtered level
  always_comb begin
    case (edge_sel_i)
      eif_pkg::EIF_ES_RISE: hit = filt_ff & ~prev_ff;
      eif_pkg::EIF_ES_FALL: hit = ~filt_ff & prev_ff;
      eif_pkg::EIF_ES_BOTH: hit = filt_ff ^ prev_ff;
      default: hit = 1'b0; // reserved code stays silent
    endcase
  end

  // history and single-cycle request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_ff <= 1'b0;
      req_ff <= 1'b0;
    end else begin
      prev_ff <= run_i ? filt_ff : prev_ff;
      req_ff <= run_i & hit;
    end
  end

  assign req_o = req_ff;
  assign filt_o = filt_ff;

  rise_req_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($rose(filt_ff) && run_i && edge_sel_i == eif_pkg::EIF_ES_RISE) |=> req_o)
    else $error("rising edge gave no request");
  fall_req_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($fell(filt_ff) && run_i && edge_sel_i == eif_pkg::EIF_ES_FALL) |=> req_o)
    else $error("falling edge gave no request");
  both_req_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!$stable(filt_ff) && run_i && edge_sel_i == eif_pkg::EIF_ES_BOTH) |=> req_o)
    else $error("edge in both mode gave no request");
  rsvd_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (edge_sel_i == eif_pkg::EIF_ES_RSVD) |=> !req_o)
    else $error("reserved edge code produced a request");
  req_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_o |=> !req_o)
    else $error("request longer than one cycle");
  off_frozen_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !run_i |=> ($stable(filt_ff) && !req_o))
    else $error("unpowered channel moved");

endmodule

// *** core/eif_top.sv ***
// Purpose: two external request channels with noise filter, edge select
//          and level flag, configured over a classic Wishbone slave
// Assumes: mclk_i is the gear clock; lf_clk_i is the low clock from a pin
// Notes:   reads and writes answer in one wait state; unmapped reads give 0
`timescale 1ns/100ps
`include "eif_map.svh"
module eif_top #(
  parameter int CHANNELS = 2,
  parameter int FILT_SAMPLES = `EIF_FILT_SAMPLES
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic lf_clk_i,
  input wire logic external_request_ch2_i,
  input wire logic external_request_ch3_i,
  output logic ch2_request_o,
  output logic ch3_request_o
);

  // no interrupt latch or enable lives here; the request pulses feed them
  // reset release
  logic rst_meta_ff; // first reset stage
  logic rst_n_ff; // released reset used by the whole block

  // bus side
  eif_pkg::eif_bus_type bus_ff; // slave state
  logic [31:0] dat_ff; // read data held for the answer
  logic [13:0] word_idx; // word index of the access
  logic req_seen; // new request in idle
  logic wr_take; // write takes effect this edge
  logic wr_pwr; // write to the power and mode register

  // configuration
  logic [CHANNELS-1:0] run_ff; // per-channel power enables
  logic slow_ff; // one while in slow or sleep mode
  eif_pkg::eif_edge_type es_ff [CHANNELS]; // edge select per channel
  eif_pkg::eif_interval_type nc_ff [CHANNELS]; // filter interval per channel
  logic [CHANNELS-1:0] flag_ff; // level flags
  logic [CHANNELS-1:0] wr_ch; // write hits a channel control register

  // sampling
  logic [CHANNELS:0] sync_bits; // synchronised pins and low clock
  logic lf_prev_ff; // low clock level one cycle ago
  logic [1:0] lf_cnt_ff; // low clock edges within one slow sample
  logic lf_qtr_ff; // one-cycle pulse at a quarter of the low clock
  logic [3:0] div_cnt_ff [CHANNELS]; // gear dividers
  logic [CHANNELS-1:0] smpl; // sample enables
  logic [CHANNELS-1:0] req; // request pulses
  logic [CHANNELS-1:0] filt; // filtered levels

  initial begin
    if (CHANNELS != 2) begin
      $error("eif_top maps exactly two channels");
    end
  end

  // reset goes low at once and comes back on the clock
  // the flops hold the block in reset for two edges after the pin rises,
  // so every register leaves reset on the same clock edge
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // pins and low clock cross in through two stages
  // the low clock shares the synchroniser so its edges line up with the pins
  eif_sync #(
    .WIDTH(CHANNELS + 1)
  ) u_sync (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_ff),
    .async_i({lf_clk_i, external_request_ch3_i, external_request_ch2_i}),
    .sync_o(sync_bits)
  );

  // address decode on the word index; byte lanes below it are ignored
  // the two low address bits and the upper lanes never reach a register
  assign word_idx = wb_adr_i[15:2];
  assign req_seen = wb_cyc_i & wb_stb_i & (bus_ff == eif_pkg::EIF_BUS_IDLE);
  // writes land on the edge where the master sees ack, lane 0 only
  // a write with sel[0] low still gets its ack but changes nothing
  assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0]
    & (bus_ff == eif_pkg::EIF_BUS_ACK);
  assign wr_pwr = wr_take & (word_idx == `EIF_POWER_IDX);
  assign wr_ch[0] = wr_take & (word_idx == `EIF_CH2_CTRL_IDX);
  assign wr_ch[1] = wr_take & (word_idx == `EIF_CH3_CTRL_IDX);

  // one wait state then ack for one cycle; any address is answered
  always_ff @(posedge mclk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      bus_ff <= eif_pkg::EIF_BUS_IDLE;
    end else begin
      case (bus_ff)
        eif_pkg::EIF_BUS_IDLE: begin
          bus_ff <= req_seen ? eif_pkg::EIF_BUS_ACK : eif_pkg::EIF_BUS_IDLE;
        end
        eif_pkg::EIF_BUS_ACK: begin
          bus_ff <= eif_pkg::EIF_BUS_IDLE; // ack drops the next cycle
        end
        default: begin
          bus_ff <= eif_pkg::EIF_BUS_IDLE;
        end
      endcase
    end
  end

  // ack comes straight from the state flop, so it is free of glitches
  assign wb_ack_o = (bus_ff == eif_pkg::EIF_BUS_ACK);

  // read data captured at the request; unused bits and unmapped words read 0
  // capturing at the request keeps dat_o steady for the whole ack cycle;
  // a flag that moves during the wait state shows its old value
  always_ff @(posedge mclk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      dat_ff <= 32'h0000_0000;
    end else if (req_seen) begin
      case (word_idx)
        `EIF_CH2_CTRL_IDX: begin
          dat_ff <= {27'h0000000, flag_ff[0], es_ff[0], nc_ff[0]};
        end
        `EIF_CH3_CTRL_IDX: begin
          dat_ff <= {27'h0000000, flag_ff[1], es_ff[1], nc_ff[1]};
        end
        `EIF_POWER_IDX: begin
          dat_ff <= {24'h000000, slow_ff, 3'h0, run_ff, 2'h0};
        end
        default: begin
          dat_ff <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign wb_dat_o = dat_ff;

  // power enables and operating mode
  // software masks the channel interrupts before this write; a switch can
  // leave a half-filled filter window that yields one stray request
  always_ff @(posedge mclk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      run_ff <= 2'h0;
      slow_ff <= 1'b0;
    end else if (wr_pwr) begin
      run_ff <= {wb_dat_i[`EIF_PWR_CH3_BIT], wb_dat_i[`EIF_PWR_CH2_BIT]};
      slow_ff <= wb_dat_i[`EIF_PWR_SLOW_BIT];
    end
  end

  // low clock edge detect and divide by four for slow sampling
  // the low clock is only a pin level here, so its edges are seen two
  // gear cycles late; slow sampling is therefore a little behind the pin
  always_ff @(posedge mclk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      lf_prev_ff <= 1'b0;
      lf_cnt_ff <= 2'h0;
      lf_qtr_ff <= 1'b0;
    end else begin
      lf_prev_ff <= sync_bits[CHANNELS];
      lf_qtr_ff <= 1'b0;
      if (sync_bits[CHANNELS] && !lf_prev_ff) begin
        lf_cnt_ff <= lf_cnt_ff + 2'h1;
        lf_qtr_ff <= (lf_cnt_ff == 2'(`EIF_SLOW_DIV - 1));
      end
    end
  end

  // per-channel registers, dividers and filter instances
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch

    // control fields; ignored while the channel has no clock
    // a new edge code acts at once; a switch in the cycle where the filtered
    // level has just moved can give one stray request, so software masks first
    always_ff @(posedge mclk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        es_ff[ch] <= eif_pkg::EIF_ES_RISE;
        nc_ff[ch] <= eif_pkg::EIF_NC_DIV1;
      end else if (wr_ch[ch] && run_ff[ch]) begin
        es_ff[ch] <= eif_pkg::eif_edge_type'(wb_dat_i[`EIF_ES_LSB +: 2]);
        nc_ff[ch] <= eif_pkg::eif_interval_type'(wb_dat_i[`EIF_NC_LSB +: 2]);
      end
    end

    // level flag takes the filtered level with each request
    // the flag only ever copies the filter output, so no set and clear race
    always_ff @(posedge mclk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        flag_ff[ch] <= 1'b0;
      end else if (req[ch]) begin
        flag_ff[ch] <= filt[ch];
      end
    end

    // gear divider; held at zero when slow or unpowered
    // a mode or power change restarts the count, so the first fast sample
    // after such a change comes at a fresh interval boundary
    always_ff @(posedge mclk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        div_cnt_ff[ch] <= 4'h0;
      end else if (!run_ff[ch] || slow_ff) begin
        div_cnt_ff[ch] <= 4'h0;
      end else if (div_cnt_ff[ch] >= eif_pkg::eif_terminal(nc_ff[ch])) begin
        div_cnt_ff[ch] <= 4'h0;
      end else begin
        div_cnt_ff[ch] <= div_cnt_ff[ch] + 4'h1;
      end
    end

    // slow modes ignore the interval code entirely
    // at or past the end count samples, so a shorter code never skips one
    assign smpl[ch] = slow_ff ? lf_qtr_ff
      : (div_cnt_ff[ch] >= eif_pkg::eif_terminal(nc_ff[ch]));

    eif_chan #(
      .FILT_SAMPLES(FILT_SAMPLES)
    ) u_chan (
      .clk_i(mclk_i),
      .rst_n_i(rst_n_ff),
      .run_i(run_ff[ch]),
      .smpl_i(smpl[ch]),
      .pin_i(sync_bits[ch]),
      .edge_sel_i(es_ff[ch]),
      .req_o(req[ch]),
      .filt_o(filt[ch])
    );

    // per-channel checks: flag, sample rates and write blocking
    flag_update_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
      req[ch] |=> (flag_ff[ch] == $past(filt[ch])))
      else $error("level flag missed the request level");
    flag_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
      !req[ch] |=> $stable(flag_ff[ch]))
      else $error("level flag changed without a request");
    slow_rate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
      (slow_ff && smpl[ch]) |-> (lf_cnt_ff == 2'h0 && $past(sync_bits[CHANNELS])
        && !$past(lf_prev_ff)))
      else $error("slow sample not on the fourth low clock edge");
    ctrl_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
      (wr_ch[ch] && run_ff[ch]) |=> (es_ff[ch] == $past(wb_dat_i[3:2])
        && nc_ff[ch] == $past(wb_dat_i[1:0])))
      else $error("write to a powered channel was lost");
    div8_gap_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
      (smpl[ch] && !slow_ff && run_ff[ch] && nc_ff[ch] == eif_pkg::EIF_NC_DIV8
        && !wr_pwr && !wr_ch[ch]) |=> !smpl[ch] [*7])
      else $error("divide by eight sampled too often");
    slow_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
      slow_ff |=> (div_cnt_ff[ch] == 4'h0))
      else $error("gear divider ran in slow mode");
    div4_gap_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
      (smpl[ch] && !slow_ff && run_ff[ch] && nc_ff[ch] == eif_pkg::EIF_NC_DIV4
        && !wr_pwr && !wr_ch[ch]) |=> !smpl[ch] [*3])
      else $error("divide by four sampled too often");
    div1_rate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
      (!slow_ff && run_ff[ch] && nc_ff[ch] == eif_pkg::EIF_NC_DIV1) |-> smpl[ch])
      else $error("divide by one missed a sample");
    off_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
      (wr_ch[ch] && !run_ff[ch]) |=> ($stable(es_ff[ch]) && $stable(nc_ff[ch])))
      else $error("write landed on an unpowered channel");
  end

  // requests leave straight from the channel flops for the interrupt latch
  assign ch2_request_o = req[0];
  assign ch3_request_o = req[1];

  // bus and slow tick checks: reserved bits, answer timing, unmapped words and tick width
  top_bits_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (wb_ack_o && (word_idx == `EIF_CH2_CTRL_IDX || word_idx == `EIF_CH3_CTRL_IDX))
      |-> (wb_dat_o[31:5] == 27'h0000000))
    else $error("reserved control bits read non-zero");
  bus_ack_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle after request");
  lf_quarter_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    lf_qtr_ff |=> !lf_qtr_ff)
    else $error("slow sample tick longer than one cycle");
  ack_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus answer longer than one cycle");
  unmapped_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (wb_ack_o && word_idx != `EIF_CH2_CTRL_IDX && word_idx != `EIF_CH3_CTRL_IDX
      && word_idx != `EIF_POWER_IDX) |-> (wb_dat_o == 32'h0000_0000))
    else $error("unmapped word read non-zero");
  pwr_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (wb_ack_o && word_idx == `EIF_POWER_IDX) |-> (wb_dat_o[31:8] == 24'h000000
      && wb_dat_o[6:4] == 3'h0 && wb_dat_o[1:0] == 2'h0))
    else $error("unused power bits read non-zero");
  pwr_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    wr_pwr |=> (run_ff == $past(wb_dat_i[3:2]) && slow_ff == $past(wb_dat_i[7])))
    else $error("power and mode write was lost");

endmodule

// *** testbench/eif_pin_model.sv ***
// Purpose: board side of the two request pins and the low-frequency clock
// Assumes: the gear clock paces every change, so the low clock has a fixed ratio
// Notes:   pins idle low; the low clock runs free, as an oscillator would
`timescale 1ns/100ps
module eif_pin_model #(
  parameter int LF_HALF = 8
) (
  input wire logic mclk_i,
  output logic [1:0] pin_o,
  output logic lf_clk_o
);
  int lf_cnt; // gear cycles into the current low clock half period

  initial begin
    pin_o = 2'h0;
    lf_clk_o = 1'b0;
    lf_cnt = 0;
  end

  // low clock: whole gear cycles per half keep the slow sample spacing exact
  always @(posedge mclk_i) begin
    if (lf_cnt == LF_HALF - 1) begin
      lf_cnt <= 0;
      lf_clk_o <= ~lf_clk_o;
    end else begin
      lf_cnt <= lf_cnt + 1;
    end
  end

  // invert one pin for a number of gear cycles, then restore it
  task automatic pulse(input int ch, input int width);
    @(posedge mclk_i);
    pin_o[ch] <= ~pin_o[ch];
    repeat (width) @(posedge mclk_i);
    pin_o[ch] <= ~pin_o[ch];
  endtask
endmodule

// *** testbench/ext_irq_edge_noise_filter_tb.sv ***
// Purpose: self-checking bench for the two-channel edge and noise filter block
// Assumes: bus task waits for ack however long; pins and low clock from the pin model
// Notes:   read data is checked from a queue at ack; requests are counted
`timescale 1ns/100ps
module ext_irq_edge_noise_filter_tb;
  localparam int LF_HALF = 8; // low clock half period in gear cycles
  localparam logic [15:0] A_CH2 = 16'h3F64; // channel 2 control
  localparam logic [15:0] A_CH3 = 16'h3F68; // channel 3 control
  localparam logic [15:0] A_PWR = 16'h3DDC; // power and mode
  localparam logic [15:0] A_NONE = 16'h0100; // nothing mapped here
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0000_0000;
  wire [31:0] dat_r;
  wire ack;
  wire lf_clk;
  wire [1:0] pin;
  wire [1:0] req;
  logic [7:0] exp_q[$]; // expected read bytes, oldest first
  logic [7:0] cnt[2] = '{8'h00, 8'h00}; // request pulses seen per channel
  int fails = 0;
  int compares = 0;
  int seed = 32'h0708578A;
  int div;

  always #10 mclk_i = ~mclk_i;

  eif_top eif_top_i (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .lf_clk_i(lf_clk),
    .external_request_ch2_i(pin[0]), .external_request_ch3_i(pin[1]),
    .ch2_request_o(req[0]), .ch3_request_o(req[1])
  );

  eif_pin_model #(.LF_HALF(LF_HALF)) eif_pin_model_i (
    .mclk_i(mclk_i), .pin_o(pin), .lf_clk_o(lf_clk)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one classic cycle; junk in upper lanes and adr[1:0] must not matter
  task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
    logic [31:0] r;
    r = $random(seed);
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a[15:2], r[5:4]};
    sel <= {r[3:1], 1'b1};
    dat_w <= {r[31:8], d};
    if (!w) begin
      exp_q.push_back(d);
    end
    @(posedge mclk_i);
    while (ack !== 1'b1) @(posedge mclk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // pulse a pin, let the filter settle, then compare the request count
  task automatic pulse_count(input int ch, input int width, input int tail, input logic [7:0] n);
    cnt[ch] = 8'h00;
    eif_pin_model_i.pulse(ch, width);
    repeat (tail) @(posedge mclk_i);
    check("request count", {24'h0, cnt[ch]}, {24'h0, n});
  endtask

  // read data is taken at the rising edge where ack is seen high
  always @(posedge mclk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      check("read data", dat_r, {24'h0, exp_q.pop_front()});
    end
  end

  // a request held two cycles would count twice
  always @(negedge mclk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (req[c] === 1'b1) begin
        cnt[c] = cnt[c] + 8'h01;
      end
    end
  end

  initial begin
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    bus(A_CH2, 1'b0, 8'h00);
    bus(A_CH3, 1'b0, 8'h00);
    bus(A_PWR, 1'b0, 8'h00);
    bus(A_NONE, 1'b0, 8'h00);
    // unpowered: write dropped, pin ignored
    bus(A_CH2, 1'b1, 8'h05);
    bus(A_CH2, 1'b0, 8'h00);
    pulse_count(0, 30, 20, 8'h00);
    bus(A_PWR, 1'b1, 8'h0C);
    bus(A_PWR, 1'b0, 8'h0C);
    bus(A_CH2, 1'b1, 8'hFF);
    bus(A_CH2, 1'b0, 8'h0F);
    // every edge code on both channels, pin steady while writing
    for (int ch = 0; ch < 2; ch++) begin
      for (int es = 0; es < 4; es++) begin
        bus(ch ? A_CH3 : A_CH2, 1'b1, {4'h0, es[1:0], 2'b00});
        pulse_count(ch, 20, 20, (es == 2) ? 8'h02 : (es == 3) ? 8'h00 : 8'h01);
        bus(ch ? A_CH3 : A_CH2, 1'b0, {3'h0, es == 0, es[1:0], 2'b00});
      end
    end
    // glitch of one or two cycles never passes the fastest filter
    bus(A_CH2, 1'b1, 8'h08);
    pulse_count(0, 1 + ($random(seed) & 1), 20, 8'h00);
    // each interval: two sample periods is noise, longer is signal
    for (int nc = 0; nc < 4; nc++) begin
      div = (nc == 0) ? 1 : (2 << nc);
      bus(A_CH3, 1'b1, {6'h02, nc[1:0]});
      pulse_count(1, 2 * div, 4 * div + 10, 8'h00);
      pulse_count(1, 4 * div + 4, 4 * div + 10, 8'h02);
    end
    // slow mode: interval field 00 must not speed the sampling up
    bus(A_PWR, 1'b1, 8'h8C);
    repeat (24 * LF_HALF) @(posedge mclk_i);
    bus(A_CH3, 1'b1, 8'h08);
    pulse_count(1, 16 * LF_HALF, 300, 8'h00);
    pulse_count(1, 300, 300, 8'h02);
    bus(A_PWR, 1'b1, 8'h0C);
    repeat (8) @(posedge mclk_i);
    pulse_count(1, 20, 20, 8'h02);
    // reset in mid-run: configuration returns to zero
    resetn_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    bus(A_CH3, 1'b0, 8'h00);
    bus(A_PWR, 1'b0, 8'h00);
    repeat (2) @(posedge mclk_i);
    check("reads left", exp_q.size(), 32'h0000_0000);
    close_out;
  end

  // watchdog: the whole sequence needs well under this
  initial begin
    repeat (30000) @(posedge mclk_i);
    fails++;
    close_out;
  end
endmodule
